// File: rtl/ucc_pkg.sv
// shared constants and types for the channel command and clock select block
package ucc_pkg;

  // register offsets on the parallel bus
  localparam logic [3:0] UCC_OFS_CLK_SEL_A = 4'h1;
  localparam logic [3:0] UCC_OFS_CMD_A     = 4'h2;
  localparam logic [3:0] UCC_OFS_CLK_SEL_B = 4'h9;
  localparam logic [3:0] UCC_OFS_CMD_B     = 4'hA;

  // command and clock select register field positions
  localparam int UCC_BIT_RX_ON   = 0;
  localparam int UCC_BIT_RX_OFF  = 1;
  localparam int UCC_BIT_TX_ON   = 2;
  localparam int UCC_BIT_TX_OFF  = 3;
  localparam int UCC_CMD_LSB     = 4;
  localparam int UCC_RX_SEL_LSB  = 4;
  localparam int UCC_TX_SEL_LSB  = 0;

  // miscellaneous command codes
  localparam logic [3:0] UCC_CMD_NONE       = 4'h0;
  localparam logic [3:0] UCC_CMD_MR_PTR_RST = 4'h1;
  localparam logic [3:0] UCC_CMD_RX_RST     = 4'h2;
  localparam logic [3:0] UCC_CMD_TX_RST     = 4'h3;
  localparam logic [3:0] UCC_CMD_ERR_CLR    = 4'h4;
  localparam logic [3:0] UCC_CMD_BRK_CLR    = 4'h5;
  localparam logic [3:0] UCC_CMD_PD_ON      = 4'hE;
  localparam logic [3:0] UCC_CMD_PD_OFF     = 4'hF;

  // clock select codes
  localparam logic [3:0] UCC_SEL_TIMER  = 4'hD;
  localparam logic [3:0] UCC_SEL_PIN16  = 4'hE;
  localparam logic [3:0] UCC_SEL_PIN1   = 4'hF;

  // values after reset
  localparam logic [7:0] UCC_RST_CLK_SEL = 8'h00;
  localparam logic [1:0] UCC_RST_CHAN    = 2'h0;
  localparam logic       UCC_RST_BIT     = 1'b0;

  typedef enum logic [2:0] {
    UCC_SRC_TABLE = 3'b001,
    UCC_SRC_TIMER = 3'b010,
    UCC_SRC_PIN   = 3'b100
  } ucc_src_t;

endpackage

// File: rtl/ucc_clk_dec.sv
// decodes one four-bit clock select field into source and rate multiple
`timescale 1ns/10ps
`default_nettype none
module ucc_clk_dec
  import ucc_pkg::*;
(
  input  wire logic [3:0] sel_in,   // clock select field
  output ucc_src_t        src_out,  // chosen clock source
  output logic            x1_out    // clock is 1x bit rate
);

  assign src_out = (sel_in == UCC_SEL_PIN16 || sel_in == UCC_SEL_PIN1) ? UCC_SRC_PIN :
                   (sel_in == UCC_SEL_TIMER) ? UCC_SRC_TIMER : UCC_SRC_TABLE;
  // only the pin 1x code runs at one times
  assign x1_out = (sel_in == UCC_SEL_PIN1);

endmodule
`default_nettype wire

// File: rtl/ucc_cmd_dec.sv
// decodes one command register write into channel actions
`timescale 1ns/10ps
`default_nettype none
module ucc_cmd_dec
  import ucc_pkg::*;
(
  input  wire logic       take_in,     // write to this channel this cycle
  input  wire logic [7:0] data_in,     // written byte
  input  wire logic       has_pd_in,   // channel owns power-down codes
  output logic            tx_on_out,   // enable transmitter
  output logic            tx_off_out,  // disable transmitter
  output logic            rx_on_out,   // enable receiver
  output logic            rx_off_out,  // disable receiver
  output logic            mr_rst_out,  // mode pointer reset
  output logic            rx_rst_out,  // receiver reset
  output logic            tx_rst_out,  // transmitter reset
  output logic            err_clr_out, // error status clear
  output logic            brk_clr_out, // break change clear
  output logic            pd_on_out,   // power-down on
  output logic            pd_off_out   // power-down off
);

  wire logic [3:0] code = data_in[UCC_CMD_LSB +: 4];

  assign tx_on_out  = take_in & data_in[UCC_BIT_TX_ON];
  assign tx_off_out = take_in & data_in[UCC_BIT_TX_OFF];
  assign rx_on_out  = take_in & data_in[UCC_BIT_RX_ON];
  assign rx_off_out = take_in & data_in[UCC_BIT_RX_OFF];
  // code zero yields no pulse at all
  assign mr_rst_out  = take_in & (code == UCC_CMD_MR_PTR_RST);
  assign rx_rst_out  = take_in & (code == UCC_CMD_RX_RST);
  assign tx_rst_out  = take_in & (code == UCC_CMD_TX_RST);
  assign err_clr_out = take_in & (code == UCC_CMD_ERR_CLR);
  assign brk_clr_out = take_in & (code == UCC_CMD_BRK_CLR);
  // power-down codes ignored on channel b
  assign pd_on_out  = take_in & has_pd_in & (code == UCC_CMD_PD_ON);
  assign pd_off_out = take_in & has_pd_in & (code == UCC_CMD_PD_OFF);

endmodule
`default_nettype wire

// File: rtl/ucc_top.sv
// channel command decode and baud clock source select for both channels
`timescale 1ns/10ps
`default_nettype none
// How it works
// - channel b receiver select: table, pin six 16x at 1110, 1x at 1111
// - channel b receiver clock is 16x except code 1111
// - channel b transmitter select: table, pin five 16x at 1110, 1x at 1111
// - channel b transmitter clock is 16x except code 1111
// - command byte: upper code, bits 3..0 tx off, tx on, rx off, rx on
// - tx disable clears ready and empty, but drains pending characters
// - tx enable starts transmitter, flags set when it is idle
// - rx disable stops at once, status and controls untouched
// - multi-drop mode keeps receiver running while disabled
// - rx enable activates and forces start-bit search unless wake-up mode
// - code 0000 does nothing, 0001 resets mode register pointer
// - code 0010 resets receiver like hardware reset, disabled and flushed
// - code 0011 resets transmitter like hardware reset
// - code 0100 clears break, framing, parity and overrun flags
// - code 0101 clears break-detect-change interrupt flag
// - channel a mirrors b with pins four and three
// - codes 0000..1100 pick table rates, 1101 picks counter/timer
// - channel b decodes like a but ignores power-down codes
module ucc_top
  import ucc_pkg::*;
(
  input  wire logic       clk_sys_in,          // crystal clock domain
  input  wire logic       arst_n_in,           // async reset, active low
  input  wire logic       ce_in,               // clock enable, freezes all state
  input  wire logic       bus_cs_n_in,         // chip select, active low
  input  wire logic       bus_wr_n_in,         // write strobe, active low
  input  wire logic [3:0] bus_addr_in,         // register offset
  input  wire logic [7:0] bus_data_in,         // write data
  input  wire logic       input_pin_three,     // channel a tx external clock
  input  wire logic       input_pin_four,      // channel a rx external clock
  input  wire logic       input_pin_five,      // channel b tx external clock
  input  wire logic       input_pin_six,       // channel b rx external clock
  input  wire logic [1:0] tx_idle_in,          // per channel: nothing to send
  input  wire logic [1:0] tx_fifo_full_in,     // per channel: tx fifo full
  input  wire logic [1:0] multidrop_in,        // per channel: multi-drop mode
  input  wire logic [1:0] wakeup_in,           // per channel: wake-up mode
  output logic      [1:0] tx_enable_out,       // transmitter enabled
  output logic      [1:0] tx_active_out,       // transmitter running or draining
  output logic      [1:0] tx_ready_flag_out,   // transmitter ready status
  output logic      [1:0] tx_empty_flag_out,   // transmitter empty status
  output logic      [1:0] rx_enable_out,       // receiver enabled by command
  output logic      [1:0] rx_run_out,          // receiver operating
  output logic      [1:0] rx_hunt_out,         // pulse: search for start bit
  output logic      [1:0] rx_reset_out,        // pulse: receiver reset and flush
  output logic      [1:0] tx_reset_out,        // pulse: transmitter reset
  output logic      [1:0] err_clear_out,       // pulse: clear status bits 7..4
  output logic      [1:0] brk_chg_clear_out,   // pulse: clear break change flag
  output logic      [1:0] mr_ptr_reset_out,    // pulse: point to first mode reg
  output logic            power_down_out,      // oscillator power-down request
  output logic      [7:0] rx_table_code_out,   // rx select per channel, b high
  output logic      [7:0] tx_table_code_out,   // tx select per channel, b high
  output logic      [1:0] rx_use_timer_out,    // rx clocked by counter/timer
  output logic      [1:0] tx_use_timer_out,    // tx clocked by counter/timer
  output logic      [1:0] rx_use_pin_out,      // rx clocked by its input pin
  output logic      [1:0] tx_use_pin_out,      // tx clocked by its input pin
  output logic      [1:0] rx_clk_1x_out,       // rx clock is 1x bit rate
  output logic      [1:0] tx_clk_1x_out,       // tx clock is 1x bit rate
  output logic      [1:0] rx_pin_clk_out,      // selected rx pin level
  output logic      [1:0] tx_pin_clk_out       // selected tx pin level
);

  logic       strobe_q_reg;
  logic [7:0] chan_a_clk_select_reg;
  logic [7:0] chan_b_clk_select_reg;
  logic [1:0] tx_en_reg,   tx_en_next;
  logic [1:0] rx_en_reg,   rx_en_next;
  logic [1:0] tx_rdy_reg,  tx_rdy_next;
  logic [1:0] tx_emp_reg,  tx_emp_next;
  logic [1:0] tx_act_reg,  tx_act_next;
  logic [1:0] rx_run_reg,  rx_run_next;
  logic [1:0] hunt_reg,    hunt_next;
  logic [1:0] rx_rst_reg,  tx_rst_reg;
  logic [1:0] err_clr_reg, brk_clr_reg, mr_rst_reg;
  logic       pd_reg,      pd_next;
  logic [1:0] rx_tim_reg,  tx_tim_reg, rx_pin_reg, tx_pin_reg;
  logic [1:0] rx_x1_reg,   tx_x1_reg,  rx_pclk_reg, tx_pclk_reg;

  // a write is taken once per strobe, on the first cycle it is seen low
  wire logic wr_strobe = ~bus_cs_n_in & ~bus_wr_n_in;
  wire logic wr_take   = wr_strobe & ~strobe_q_reg;
  wire logic wr_csa    = wr_take & (bus_addr_in == UCC_OFS_CLK_SEL_A);
  wire logic wr_csb    = wr_take & (bus_addr_in == UCC_OFS_CLK_SEL_B);
  wire logic [1:0] wr_cmd;
  assign wr_cmd[0] = wr_take & (bus_addr_in == UCC_OFS_CMD_A);
  assign wr_cmd[1] = wr_take & (bus_addr_in == UCC_OFS_CMD_B);

  wire logic [1:0] tx_on, tx_off, rx_on, rx_off, mr_rst, rx_rst, tx_rst;
  wire logic [1:0] err_clr, brk_clr, pd_on, pd_off;

  // clock select field views, index 0 channel a, 1 channel b
  wire logic [3:0] rx_sel [2];
  wire logic [3:0] tx_sel [2];
  assign rx_sel[0] = chan_a_clk_select_reg[UCC_RX_SEL_LSB +: 4];
  assign rx_sel[1] = chan_b_clk_select_reg[UCC_RX_SEL_LSB +: 4];
  assign tx_sel[0] = chan_a_clk_select_reg[UCC_TX_SEL_LSB +: 4];
  assign tx_sel[1] = chan_b_clk_select_reg[UCC_TX_SEL_LSB +: 4];
  // fixed pin per direction and channel
  wire logic [1:0] rx_pin_lvl = {input_pin_six, input_pin_four};
  wire logic [1:0] tx_pin_lvl = {input_pin_five, input_pin_three};

  ucc_src_t   rx_src [2];
  ucc_src_t   tx_src [2];
  wire logic [1:0] rx_x1, tx_x1;

  genvar ch;
  generate
    for (ch = 0; ch < 2; ch++) begin : g_chan
      ucc_cmd_dec u_cmd (
        .take_in     (wr_cmd[ch]),
        .data_in     (bus_data_in),
        .has_pd_in   (ch == 0),
        .tx_on_out   (tx_on[ch]),
        .tx_off_out  (tx_off[ch]),
        .rx_on_out   (rx_on[ch]),
        .rx_off_out  (rx_off[ch]),
        .mr_rst_out  (mr_rst[ch]),
        .rx_rst_out  (rx_rst[ch]),
        .tx_rst_out  (tx_rst[ch]),
        .err_clr_out (err_clr[ch]),
        .brk_clr_out (brk_clr[ch]),
        .pd_on_out   (pd_on[ch]),
        .pd_off_out  (pd_off[ch])
      );
      ucc_clk_dec u_rx_clk (
        .sel_in  (rx_sel[ch]),
        .src_out (rx_src[ch]),
        .x1_out  (rx_x1[ch])
      );
      ucc_clk_dec u_tx_clk (
        .sel_in  (tx_sel[ch]),
        .src_out (tx_src[ch]),
        .x1_out  (tx_x1[ch])
      );

      // disable wins, and resets act like disable
      assign tx_en_next[ch] = (tx_off[ch] | tx_rst[ch]) ? 1'b0 :
                              tx_on[ch] ? 1'b1 : tx_en_reg[ch];
      assign rx_en_next[ch] = (rx_off[ch] | rx_rst[ch]) ? 1'b0 :
                              rx_on[ch] ? 1'b1 : rx_en_reg[ch];
      // flags only while enabled, cleared on disable
      assign tx_rdy_next[ch] = tx_en_next[ch] & ~tx_fifo_full_in[ch];
      assign tx_emp_next[ch] = tx_en_next[ch] & tx_idle_in[ch];
      // disabled transmitter still drains, a reset stops it
      assign tx_act_next[ch] = tx_en_next[ch] | (~tx_rst[ch] & ~tx_idle_in[ch]);
      // stop at once unless multi-drop keeps it going
      assign rx_run_next[ch] = rx_en_next[ch] | (multidrop_in[ch] & ~rx_rst[ch]);
      // start-bit search on enable outside wake-up mode
      assign hunt_next[ch] = rx_on[ch] & ~rx_off[ch] & ~rx_rst[ch] & ~wakeup_in[ch];
    end
  endgenerate

  // only channel a can change the power-down state
  assign pd_next = pd_off[0] ? 1'b0 : pd_on[0] ? 1'b1 : pd_reg;

  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      strobe_q_reg          <= UCC_RST_BIT;
      chan_a_clk_select_reg <= UCC_RST_CLK_SEL;
      chan_b_clk_select_reg <= UCC_RST_CLK_SEL;
    end else if (ce_in) begin
      strobe_q_reg <= wr_strobe;
      if (wr_csa) begin
        chan_a_clk_select_reg <= bus_data_in;
      end
      if (wr_csb) begin
        chan_b_clk_select_reg <= bus_data_in;
      end
    end
  end

  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      tx_en_reg  <= UCC_RST_CHAN;
      rx_en_reg  <= UCC_RST_CHAN;
      tx_rdy_reg <= UCC_RST_CHAN;
      tx_emp_reg <= UCC_RST_CHAN;
      tx_act_reg <= UCC_RST_CHAN;
      rx_run_reg <= UCC_RST_CHAN;
      pd_reg     <= UCC_RST_BIT;
    end else if (ce_in) begin
      tx_en_reg  <= tx_en_next;
      rx_en_reg  <= rx_en_next;
      tx_rdy_reg <= tx_rdy_next;
      tx_emp_reg <= tx_emp_next;
      tx_act_reg <= tx_act_next;
      rx_run_reg <= rx_run_next;
      pd_reg     <= pd_next;
    end
  end

  // one-cycle command pulses
  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      hunt_reg    <= UCC_RST_CHAN;
      rx_rst_reg  <= UCC_RST_CHAN;
      tx_rst_reg  <= UCC_RST_CHAN;
      err_clr_reg <= UCC_RST_CHAN;
      brk_clr_reg <= UCC_RST_CHAN;
      mr_rst_reg  <= UCC_RST_CHAN;
    end else if (ce_in) begin
      hunt_reg    <= hunt_next;
      rx_rst_reg  <= rx_rst;
      tx_rst_reg  <= tx_rst;
      err_clr_reg <= err_clr;
      brk_clr_reg <= brk_clr;
      mr_rst_reg  <= mr_rst;
    end
  end

  // clock source outputs re-registered so every output leaves a flop
  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rx_tim_reg  <= UCC_RST_CHAN;
      tx_tim_reg  <= UCC_RST_CHAN;
      rx_pin_reg  <= UCC_RST_CHAN;
      tx_pin_reg  <= UCC_RST_CHAN;
      rx_x1_reg   <= UCC_RST_CHAN;
      tx_x1_reg   <= UCC_RST_CHAN;
      rx_pclk_reg <= UCC_RST_CHAN;
      tx_pclk_reg <= UCC_RST_CHAN;
    end else if (ce_in) begin
      for (int i = 0; i < 2; i++) begin
        rx_tim_reg[i]  <= (rx_src[i] == UCC_SRC_TIMER);
        tx_tim_reg[i]  <= (tx_src[i] == UCC_SRC_TIMER);
        rx_pin_reg[i]  <= (rx_src[i] == UCC_SRC_PIN);
        tx_pin_reg[i]  <= (tx_src[i] == UCC_SRC_PIN);
        rx_x1_reg[i]   <= rx_x1[i];
        tx_x1_reg[i]   <= tx_x1[i];
        // gated pin clock, low when the pin is not selected
        rx_pclk_reg[i] <= (rx_src[i] == UCC_SRC_PIN) & rx_pin_lvl[i];
        tx_pclk_reg[i] <= (tx_src[i] == UCC_SRC_PIN) & tx_pin_lvl[i];
      end
    end
  end

  assign tx_enable_out     = tx_en_reg;
  assign tx_active_out     = tx_act_reg;
  assign tx_ready_flag_out = tx_rdy_reg;
  assign tx_empty_flag_out = tx_emp_reg;
  assign rx_enable_out     = rx_en_reg;
  assign rx_run_out        = rx_run_reg;
  assign rx_hunt_out       = hunt_reg;
  assign rx_reset_out      = rx_rst_reg;
  assign tx_reset_out      = tx_rst_reg;
  assign err_clear_out     = err_clr_reg;
  assign brk_chg_clear_out = brk_clr_reg;
  assign mr_ptr_reset_out  = mr_rst_reg;
  assign power_down_out    = pd_reg;
  assign rx_table_code_out = {rx_sel[1], rx_sel[0]};
  assign tx_table_code_out = {tx_sel[1], tx_sel[0]};
  assign rx_use_timer_out  = rx_tim_reg;
  assign tx_use_timer_out  = tx_tim_reg;
  assign rx_use_pin_out    = rx_pin_reg;
  assign tx_use_pin_out    = tx_pin_reg;
  assign rx_clk_1x_out     = rx_x1_reg;
  assign tx_clk_1x_out     = tx_x1_reg;
  assign rx_pin_clk_out    = rx_pclk_reg;
  assign tx_pin_clk_out    = tx_pclk_reg;

  a_dis_wins_tx: assert property (
    @(posedge clk_sys_in) disable iff (!arst_n_in)
    ce_in && wr_cmd[1] && bus_data_in[UCC_BIT_TX_OFF] |=> !tx_enable_out[1])
    else $error("tx disable did not win on channel b");

  a_tx_flags_clear: assert property (
    @(posedge clk_sys_in) disable iff (!arst_n_in)
    ce_in && wr_cmd[0] && bus_data_in[UCC_BIT_TX_OFF]
      |=> !tx_ready_flag_out[0] && !tx_empty_flag_out[0])
    else $error("tx flags not cleared on disable");

  a_tx_drain: assert property (
    @(posedge clk_sys_in) disable iff (!arst_n_in)
    ce_in && !tx_idle_in[0] && !tx_rst[0] |=> tx_active_out[0])
    else $error("transmitter stopped with data pending");

  a_tx_flags_set: assert property (
    @(posedge clk_sys_in) disable iff (!arst_n_in)
    ce_in && tx_en_next[1] && tx_idle_in[1] && !tx_fifo_full_in[1]
      |=> tx_ready_flag_out[1] && tx_empty_flag_out[1])
    else $error("tx flags not set when idle and enabled");

  a_rx_hunt_pulse: assert property (
    @(posedge clk_sys_in) disable iff (!arst_n_in)
    ce_in && wr_cmd[0] && bus_data_in[UCC_BIT_RX_ON] && !bus_data_in[UCC_BIT_RX_OFF]
      && bus_data_in[UCC_CMD_LSB +: 4] != UCC_CMD_RX_RST && !wakeup_in[0]
      |=> rx_hunt_out[0] && rx_enable_out[0])
    else $error("receiver enable missed start-bit search");

  a_rx_reset_dis: assert property (
    @(posedge clk_sys_in) disable iff (!arst_n_in)
    ce_in && wr_cmd[1] && bus_data_in[UCC_CMD_LSB +: 4] == UCC_CMD_RX_RST
      |=> (rx_reset_out[1] && !rx_enable_out[1]) ##1 (!rx_reset_out[1] || !$past(ce_in)))
    else $error("receiver reset pulse or disable wrong");

  a_multidrop_run: assert property (
    @(posedge clk_sys_in) disable iff (!arst_n_in)
    ce_in && multidrop_in[1] && !rx_rst[1] |=> rx_run_out[1])
    else $error("multi-drop receiver stopped");

  a_pd_b_ignored: assert property (
    @(posedge clk_sys_in) disable iff (!arst_n_in)
    ce_in && !wr_cmd[0] |=> $stable(power_down_out))
    else $error("power-down changed without channel a write");

  a_pin_1x_sel: assert property (
    @(posedge clk_sys_in) disable iff (!arst_n_in)
    ce_in && wr_csb && bus_data_in[UCC_RX_SEL_LSB +: 4] == UCC_SEL_PIN1
      ##1 ce_in |=> rx_clk_1x_out[1] && rx_use_pin_out[1])
    else $error("rx 1x pin select not applied");

  a_pin_16x_sel: assert property (
    @(posedge clk_sys_in) disable iff (!arst_n_in)
    ce_in && wr_csb && bus_data_in[UCC_TX_SEL_LSB +: 4] == UCC_SEL_PIN16
      ##1 ce_in |=> !tx_clk_1x_out[1] && tx_use_pin_out[1])
    else $error("tx 16x pin select not applied");

endmodule
`default_nettype wire

// File: test/ucc_host.sv
// host processor model issuing single-byte writes on the parallel bus
`timescale 1ns/10ps
`default_nettype none
module ucc_host (
  input  wire logic       clk_in,    // bus clock
  output logic            cs_n_out,  // chip select, active low
  output logic            wr_n_out,  // write strobe, active low
  output logic      [3:0] addr_out,  // register offset
  output logic      [7:0] data_out   // write data
);
  initial begin
    cs_n_out = 1'b1;
    wr_n_out = 1'b1;
    addr_out = 4'h0;
    data_out = 8'h00;
  end
  // one command set per byte, enable and disable bits may both be set
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    // three edges between commands, strobe high between writes
    repeat (3) @(negedge clk_in);
    cs_n_out = 1'b0;
    wr_n_out = 1'b0;
    addr_out = a;
    data_out = d;
    @(negedge clk_in);
    cs_n_out = 1'b1;
    wr_n_out = 1'b1;
    // a released bus must not keep showing the last byte
    addr_out = ~a;
    data_out = ~d;
  endtask
endmodule
`default_nettype wire

// File: test/ucc_top_tb.sv
// self-checking bench for command decode and clock select
`timescale 1ns/10ps
`default_nettype none
module ucc_top_tb;
  import ucc_pkg::*;
  logic clk_sys_in, arst_n_in, ce_in, bus_cs_n_in, bus_wr_n_in, power_down_out;
  logic input_pin_three, input_pin_four, input_pin_five, input_pin_six;
  logic [3:0] bus_addr_in;
  logic [7:0] bus_data_in, rx_table_code_out, tx_table_code_out;
  logic [1:0] tx_idle_in, tx_fifo_full_in, multidrop_in, wakeup_in;
  logic [1:0] tx_enable_out, tx_active_out, tx_ready_flag_out, tx_empty_flag_out;
  logic [1:0] rx_enable_out, rx_run_out, rx_hunt_out, rx_reset_out, tx_reset_out;
  logic [1:0] err_clear_out, brk_chg_clear_out, mr_ptr_reset_out;
  logic [1:0] rx_use_timer_out, tx_use_timer_out, rx_use_pin_out, tx_use_pin_out;
  logic [1:0] rx_clk_1x_out, tx_clk_1x_out, rx_pin_clk_out, tx_pin_clk_out;
  logic [3:0] r, t;
  logic [3:0] codes [5] = '{4'h0, 4'hC, 4'hD, 4'hE, 4'hF};
  int         fails, compares, k;

  ucc_host host (.clk_in(clk_sys_in), .cs_n_out(bus_cs_n_in), .wr_n_out(bus_wr_n_in),
                 .addr_out(bus_addr_in), .data_out(bus_data_in));

  ucc_top DUT (.clk_sys_in, .arst_n_in, .ce_in, .bus_cs_n_in, .bus_wr_n_in, .bus_addr_in,
    .bus_data_in, .input_pin_three, .input_pin_four, .input_pin_five, .input_pin_six,
    .tx_idle_in, .tx_fifo_full_in, .multidrop_in, .wakeup_in, .tx_enable_out,
    .tx_active_out, .tx_ready_flag_out, .tx_empty_flag_out, .rx_enable_out, .rx_run_out,
    .rx_hunt_out, .rx_reset_out, .tx_reset_out, .err_clear_out, .brk_chg_clear_out,
    .mr_ptr_reset_out, .power_down_out, .rx_table_code_out, .tx_table_code_out,
    .rx_use_timer_out, .tx_use_timer_out, .rx_use_pin_out, .tx_use_pin_out,
    .rx_clk_1x_out, .tx_clk_1x_out, .rx_pin_clk_out, .tx_pin_clk_out);

  function automatic logic [1:0] ob(input int ch, input logic v);
    return v ? (2'b01 << ch) : 2'b00;
  endfunction

  task automatic chk(input logic [9:0] got, input logic [9:0] exp, input string m);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  task automatic cmd(input int ch, input logic [7:0] d);
    host.wr(ch ? UCC_OFS_CMD_B : UCC_OFS_CMD_A, d);
  endtask

  task automatic results();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  initial begin
    clk_sys_in = 1'b0;
    forever #5 clk_sys_in = ~clk_sys_in;
  end

  initial begin
    {arst_n_in, fails, compares} = '0;
    ce_in = 1'b1;
    {input_pin_three, input_pin_four, input_pin_five, input_pin_six} = 4'h0;
    {tx_idle_in, tx_fifo_full_in, multidrop_in, wakeup_in} = 8'hC0;
    repeat (6) @(negedge clk_sys_in);
    arst_n_in = 1'b1;
    @(negedge clk_sys_in);
    chk({tx_enable_out, rx_enable_out, rx_run_out, tx_active_out, power_down_out}, 0, "reset");
    // codes 0000..0101 on both channels, pulse, then quiet on all but break clear
    for (int ch = 0; ch < 2; ch++) begin
      for (int c = 0; c < 6; c++) begin
        cmd(ch, {4'(c), 4'h0});
        chk({mr_ptr_reset_out, rx_reset_out, tx_reset_out, err_clear_out, brk_chg_clear_out},
            {ob(ch, c == 1), ob(ch, c == 2), ob(ch, c == 3), ob(ch, c == 4), ob(ch, c == 5)},
            "code pulse");
        @(negedge clk_sys_in);
        chk({mr_ptr_reset_out, rx_reset_out, tx_reset_out, err_clear_out}, 0, "pulse end");
      end
    end
    $display("test commands done");
    // combined enables with a code in one byte
    cmd(0, 8'h55);
    chk({tx_enable_out, rx_enable_out, rx_hunt_out, brk_chg_clear_out}, 8'h55, "enable A");
    @(negedge clk_sys_in);
    chk({tx_ready_flag_out, tx_empty_flag_out, rx_run_out}, 6'h15, "idle flags");
    cmd(0, 8'h0F);
    chk({tx_enable_out, rx_enable_out}, 0, "disable wins");
    @(negedge clk_sys_in);
    chk({tx_ready_flag_out, tx_empty_flag_out}, 0, "flags clear");
    $display("test enable done");
    cmd(1, 8'h04);
    tx_idle_in = 2'b01;
    tx_fifo_full_in = 2'b10;
    repeat (2) @(negedge clk_sys_in);
    chk({tx_enable_out, tx_ready_flag_out, tx_empty_flag_out}, 6'h20, "busy flags");
    cmd(1, 8'h08);
    chk({tx_enable_out, tx_active_out}, 4'h2, "draining");
    tx_idle_in = 2'b11;
    k = 0;
    while (tx_active_out !== 2'b00 && k < 8) begin
      @(negedge clk_sys_in);
      k++;
    end
    chk(tx_active_out, 0, "drain end");
    // a drain that never ends has already counted a mismatch above
    if (tx_active_out !== 2'b00)
      results();
    $display("test drain done");
    wakeup_in = 2'b10;
    multidrop_in = 2'b10;
    cmd(1, 8'h01);
    chk({rx_enable_out, rx_hunt_out}, 4'h8, "wakeup enable");
    cmd(1, 8'h02);
    chk({rx_enable_out, rx_run_out, tx_enable_out}, 6'h08, "multidrop run");
    multidrop_in = 2'b00;
    repeat (2) @(negedge clk_sys_in);
    chk(rx_run_out, 0, "rx stopped");
    cmd(0, 8'hE0);
    cmd(1, 8'hF0);
    chk(power_down_out, 1, "pd kept on B");
    cmd(0, 8'hF0);
    chk(power_down_out, 0, "pd off");
    ce_in = 1'b0;
    cmd(0, 8'h04);
    ce_in = 1'b1;
    host.wr(4'h3, 8'h05);
    chk({tx_enable_out, rx_enable_out}, 0, "frozen and unmapped");
    $display("test rx and misc done");
    {input_pin_three, input_pin_four, input_pin_five, input_pin_six} = 4'hF;
    // source, rate and pin gating per field
    for (int ch = 0; ch < 2; ch++) begin
      foreach (codes[i]) begin
        r = codes[i];
        t = codes[i] ^ 4'h1;
        host.wr(ch ? UCC_OFS_CLK_SEL_B : UCC_OFS_CLK_SEL_A, {r, t});
        repeat (2) @(negedge clk_sys_in);
        chk({rx_table_code_out[ch*4+:4], tx_table_code_out[ch*4+:4]}, {r, t}, "code");
        chk({rx_use_timer_out[ch], tx_use_timer_out[ch], rx_use_pin_out[ch],
             tx_use_pin_out[ch], rx_clk_1x_out[ch], tx_clk_1x_out[ch], rx_pin_clk_out[ch],
             tx_pin_clk_out[ch]}, {r == 4'hD, t == 4'hD, r >= 4'hE, t >= 4'hE, r == 4'hF,
             t == 4'hF, r >= 4'hE, t >= 4'hE}, "source");
      end
    end
    {input_pin_three, input_pin_four, input_pin_five, input_pin_six} = 4'h0;
    repeat (3) @(negedge clk_sys_in);
    chk({rx_pin_clk_out, tx_pin_clk_out}, 0, "pin level");
    // pins six and three high one at a time show which direction and channel each feeds
    input_pin_six = 1'b1;
    repeat (3) @(negedge clk_sys_in);
    chk({rx_pin_clk_out, tx_pin_clk_out}, 4'h8, "pin six");
    {input_pin_six, input_pin_three} = 2'b01;
    repeat (3) @(negedge clk_sys_in);
    chk({rx_pin_clk_out, tx_pin_clk_out}, 4'h1, "pin three");
    input_pin_three = 1'b0;
    $display("test clock select done");
    results();
  end
endmodule
`default_nettype wire
